// file: bench/ext_interrupt_pulse_decoder_tb.sv
// Self-checking bench for the external interrupt unit
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_pulse_decoder_tb;
  import ext_irq_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int FC = 8;
  logic        clk;
  logic        arst_n;
  logic        irq_pin;
  logic        irq_ack;
  logic        unmask_irq_op;
  logic        mask_irq_op;
  logic        write_flags_op;
  logic        read_flags_op;
  logic        read_interval_op;
  logic [3:0]  acc_in;
  logic [11:0] next_pc;
  logic        irq_req;
  logic [3:0]  acc_out;
  logic        acc_out_valid;
  logic        push_stack;
  logic [11:0] push_addr;
  logic        vector_load;
  logic [11:0] vector_addr;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          t;
  // Fifteen, 35 and 70 ticks: clear of both thresholds by the tick error
  int          gaps[3] = '{120, 280, 560};

  always #12.5 clk = ~clk;

  ext_interrupt_pulse_decoder #(.FAST_CYC(FC)) ext_interrupt_pulse_decoder_inst (
    .clk(clk), .arst_n(arst_n), .irq_pin(irq_pin),
    .unmask_irq_op(unmask_irq_op), .mask_irq_op(mask_irq_op), .write_flags_op(write_flags_op),
    .read_flags_op(read_flags_op), .read_interval_op(read_interval_op), .acc_in(acc_in),
    .irq_ack(irq_ack), .next_pc(next_pc), .irq_req(irq_req), .acc_out(acc_out),
    .acc_out_valid(acc_out_valid), .push_stack(push_stack), .push_addr(push_addr),
    .vector_load(vector_load), .vector_addr(vector_addr));

  remote_tx_model remote_tx_model_inst (.clk(clk), .pin(irq_pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // Bits: 0 unmask, 1 mask, 2 write flags, 3 read flags, 4 read interval
  task automatic do_op(input logic [4:0] m);
    @(posedge clk) {read_interval_op, read_flags_op, write_flags_op, mask_irq_op, unmask_irq_op} <= m;
    @(posedge clk) {read_interval_op, read_flags_op, write_flags_op, mask_irq_op, unmask_irq_op} <= 5'h00;
    @(negedge clk);
  endtask : do_op

  task automatic do_reset();
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
  endtask : do_reset

  task automatic wr_flags(input logic [3:0] v);
    @(posedge clk) acc_in <= v;
    do_op(5'h04);
  endtask : wr_flags

  // Polls the flags; t counts cycles from the pin's fall
  task automatic wait_pend(output int t);
    t = 0;
    do begin
      do_op(5'h08);
      t += 2;
    end while (acc_out[FLG_PENDING_BIT] !== 1'b1 && t < 100);
  endtask : wait_pend

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    do_reset();
    do_op(5'h08);
    check(12'(acc_out), 12'h000);
    check(12'(irq_req), 12'h000);
    check(vector_addr, 12'h003);
  endtask : t_reset

  task automatic t_flags();
    wr_flags(4'hf);
    do_op(5'h08);
    check(12'(acc_out), 12'h003);
    check(12'(acc_out_valid), 12'h001);
    do_op(5'h01);
    do_op(5'h08);
    check(12'(acc_out), 12'h007);
    do_op(5'h03);
    do_op(5'h08);
    check(12'(acc_out), 12'h003);
    wr_flags(4'h0);
  endtask : t_flags

  task automatic t_accept();
    fork
      remote_tx_model_inst.fall_then(40);
      wait_pend(t);
    join
    check(12'(t >= 10 && t <= 30), 12'h001);
    check(12'(acc_out), 12'h008);
    check(12'(irq_req), 12'h000);
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    @(negedge clk);
    check(12'(push_stack), 12'h000);
    do_op(5'h01);
    check(12'(irq_req), 12'h001);
    @(posedge clk) irq_ack <= 1'b1;
    next_pc <= 12'h5a5;
    @(posedge clk) irq_ack <= 1'b0;
    @(negedge clk);
    check(12'(push_stack && vector_load), 12'h001);
    check(push_addr, 12'h5a5);
    do_op(5'h08);
    check(12'(acc_out), 12'h000);
  endtask : t_accept

  task automatic t_polarity();
    do_reset();
    wr_flags(4'h1);
    remote_tx_model_inst.set_pin(1'b0);
    repeat (40) @(posedge clk);
    do_op(5'h08);
    check(12'(acc_out), 12'h001);
    fork
      remote_tx_model_inst.set_pin(1'b1);
      wait_pend(t);
    join
    check(12'(acc_out), 12'h009);
  endtask : t_polarity

  task automatic t_slow_delay();
    do_reset();
    wr_flags(4'h2);
    fork
      remote_tx_model_inst.fall_then(60);
      wait_pend(t);
    join
    check(12'(t >= 18 && t <= 46), 12'h001);
  endtask : t_slow_delay

  task automatic t_pin_level();
    remote_tx_model_inst.set_pin(1'b0);
    repeat (8) @(posedge clk);
    do_op(5'h10);
    check(12'(acc_out[RES_PIN_LEVEL]), 12'h000);
    remote_tx_model_inst.set_pin(1'b1);
  endtask : t_pin_level

  // Gap of n cycles between two falls, then the result is read
  task automatic t_interval(input logic slow, input int n);
    int          ticks;
    logic [11:0] exp;
    ticks = n / (slow ? 2 * FC : FC);
    exp = {10'h001, ticks >= int'(WORD_THRESH), ticks >= int'(BIT_THRESH)};
    do_reset();
    wr_flags({2'b00, slow, 1'b0});
    remote_tx_model_inst.fall_then(n);
    remote_tx_model_inst.fall_then(20);
    do_op(5'h10);
    check(12'(acc_out), exp);
  endtask : t_interval

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk     = 1'b0;
    arst_n  = 1'b0;
    irq_ack = 1'b0;
    {read_interval_op, read_flags_op, write_flags_op, mask_irq_op, unmask_irq_op} = 5'h00;
    acc_in  = 4'h0;
    next_pc = 12'h000;
    t_reset();
    t_flags();
    t_accept();
    t_polarity();
    t_slow_delay();
    t_pin_level();
    foreach (gaps[i]) begin
      t_interval(1'b0, gaps[i]);
      t_interval(1'b1, 2 * gaps[i]);
    end
    test_done();
  end
endmodule : ext_interrupt_pulse_decoder_tb
`default_nettype wire

// file: bench/remote_tx_model.sv
// Pin-side model of a remote control receiver
`timescale 1ns/10ps
`default_nettype none
module remote_tx_model (
  input  wire logic clk,
  output var logic  pin
);
  // Idle high, where the pin's pull-up leaves it
  initial pin = 1'b1;

  task automatic set_pin(input logic v);
    @(posedge clk) pin <= v;
  endtask : set_pin

  // Fall, low long enough for the synchroniser, next fall n cycles on
  task automatic fall_then(input int n);
    set_pin(1'b0);
    repeat (8) @(posedge clk);
    pin <= 1'b1;
    repeat (n - 9) @(posedge clk);
    @(negedge clk);
  endtask : fall_then
endmodule : remote_tx_model
`default_nettype wire

// file: design/ext_interrupt_pulse_decoder.sv
// External interrupt unit with pulse interval decoder
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_pulse_decoder #(
  parameter int FAST_CYC = ext_irq_pkg::REF_FAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        irq_pin,
  input  wire logic        unmask_irq_op,
  input  wire logic        mask_irq_op,
  input  wire logic        write_flags_op,
  input  wire logic        read_flags_op,
  input  wire logic        read_interval_op,
  input  wire logic [3:0]  acc_in,
  input  wire logic        irq_ack,
  input  wire logic [11:0] next_pc,
  output logic             irq_req,
  output logic [3:0]       acc_out,
  output logic             acc_out_valid,
  output logic             push_stack,
  output logic [11:0]      push_addr,
  output logic             vector_load,
  output logic [11:0]      vector_addr
);
  import ext_irq_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser and reference tick
  // ----------------------------------------------------------------
  logic pin_lvl;
  logic tick;
  logic edge_polarity_sel;
  logic ref_clock_sel;
  logic irq_enable_flag;
  logic irq_pending_flag;

  pin_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (irq_pin),
    .level  (pin_lvl)
  );

  ref_tick_gen #(
    .FAST_CYC (FAST_CYC)
  ) u_tick (
    .clk      (clk),
    .arst_n   (arst_n),
    .slow_sel (ref_clock_sel),
    .tick     (tick)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic pin_prev_r;
  logic pin_prev_nxt;
  logic fall_edge;
  logic rise_edge;
  logic sel_edge;

  always_comb begin
    pin_prev_nxt = pin_lvl;
    fall_edge    = pin_prev_r && !pin_lvl;
    rise_edge    = !pin_prev_r && pin_lvl;
    sel_edge     = edge_polarity_sel ? rise_edge : fall_edge;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev_r <= 1'b1;
    end else begin
      pin_prev_r <= pin_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Edge qualifier: waits a number of reference ticks
  // ----------------------------------------------------------------
  qual_state_type qstate_r;
  qual_state_type qstate_nxt;
  logic [1:0]     qcnt_r;
  logic [1:0]     qcnt_nxt;
  logic           qual_event;

  always_comb begin
    qstate_nxt = qstate_r;
    qcnt_nxt   = qcnt_r;
    qual_event = 1'b0;
    case (qstate_r)
      QS_IDLE: begin
        if (sel_edge) begin
          qstate_nxt = QS_WAIT;
          qcnt_nxt   = '0;
        end
      end
      QS_WAIT: begin
        // Phase of the free-running tick sets the spread of the delay
        if (tick) begin
          qcnt_nxt = qcnt_r + 2'h1;
          if (qcnt_r == QUAL_TICKS - 2'h1) begin
            qstate_nxt = QS_FIRE;
          end
        end
      end
      QS_FIRE: begin
        qual_event = 1'b1;
        qstate_nxt = QS_IDLE;
      end
      default: begin
        qstate_nxt = QS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qstate_r <= QS_IDLE;
      qcnt_r   <= '0;
    end else begin
      qstate_r <= qstate_nxt;
      qcnt_r   <= qcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic       accept;

  assign edge_polarity_sel = flags_r[FLG_EDGE_BIT];
  assign ref_clock_sel     = flags_r[FLG_REFCLK_BIT];
  assign irq_enable_flag   = flags_r[FLG_ENABLE_BIT];
  assign irq_pending_flag  = flags_r[FLG_PENDING_BIT];

  always_comb begin
    flags_nxt = flags_r;
    accept    = irq_ack && irq_req;
    if (write_flags_op) begin
      flags_nxt[FLG_REFCLK_BIT:FLG_EDGE_BIT] = acc_in[1:0];
    end
    if (unmask_irq_op) begin
      flags_nxt[FLG_ENABLE_BIT] = 1'b1;
    end
    if (mask_irq_op) begin
      flags_nxt[FLG_ENABLE_BIT] = 1'b0;
    end
    if (accept) begin
      flags_nxt[FLG_ENABLE_BIT]  = 1'b0;
      flags_nxt[FLG_PENDING_BIT] = 1'b0;
    end
    // New event beats a clear in the same cycle
    if (qual_event) begin
      flags_nxt[FLG_PENDING_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Pending survives while disabled and fires as soon as enabled
  assign irq_req = irq_pending_flag && irq_enable_flag;

  // ----------------------------------------------------------------
  // Interval measurement and classification
  // ----------------------------------------------------------------
  logic [INTV_W-1:0] icnt_r;
  logic [INTV_W-1:0] icnt_nxt;
  logic [1:0]        cls_r;
  logic [1:0]        cls_nxt;
  logic [INTV_W-1:0] icnt_inc;

  function automatic logic [1:0] classify(input logic [INTV_W-1:0] n);
    logic [1:0] r;
    r = 2'h0;
    if (n >= BIT_THRESH) begin
      r[RES_BIT_DATA] = 1'b1;
    end
    if (n >= WORD_THRESH) begin
      r[RES_WORD_END] = 1'b1;
    end
    return r;
  endfunction : classify

  always_comb begin
    icnt_nxt = icnt_r;
    cls_nxt  = cls_r;
    // Saturate so very long gaps still read as word end
    icnt_inc = (tick && icnt_r != {INTV_W{1'b1}}) ? icnt_r + 7'h1 : icnt_r;
    if (fall_edge) begin
      cls_nxt  = classify(icnt_inc);
      icnt_nxt = '0;
    end else begin
      icnt_nxt = icnt_inc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      icnt_r <= '0;
      cls_r  <= RESULT_RESET[1:0];
    end else begin
      icnt_r <= icnt_nxt;
      cls_r  <= cls_nxt;
    end
  end

  logic [2:0] interval_result;
  assign interval_result = {pin_lvl, cls_r};

  // ----------------------------------------------------------------
  // Accumulator read path and vectoring
  // ----------------------------------------------------------------
  logic [3:0]  acc_r;
  logic [3:0]  acc_nxt;
  logic        accv_r;
  logic        accv_nxt;
  logic        push_r;
  logic [11:0] paddr_r;
  logic [11:0] paddr_nxt;

  always_comb begin
    acc_nxt   = acc_r;
    accv_nxt  = read_flags_op || read_interval_op;
    paddr_nxt = paddr_r;
    if (read_flags_op) begin
      acc_nxt = flags_r;
    end else if (read_interval_op) begin
      acc_nxt = {1'b0, interval_result};
    end
    if (accept) begin
      paddr_nxt = next_pc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r   <= 4'h0;
      accv_r  <= 1'b0;
      push_r  <= 1'b0;
      paddr_r <= 12'h000;
    end else begin
      acc_r   <= acc_nxt;
      accv_r  <= accv_nxt;
      push_r  <= accept;
      paddr_r <= paddr_nxt;
    end
  end

  assign acc_out       = acc_r;
  assign acc_out_valid = accv_r;
  assign push_stack    = push_r;
  assign push_addr     = paddr_r;
  assign vector_load   = push_r;
  assign vector_addr   = IRQ_VECTOR;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_accept;
    irq_ack && irq_req;
  endsequence

  AST_REQ_AND: assert property (@(posedge clk) disable iff (!arst_n)
    irq_req == (irq_pending_flag && irq_enable_flag))
    else $error("request differs from pending and enable");

  AST_ACCEPT_CLEARS: assert property (@(posedge clk) disable iff (!arst_n)
    s_accept |=> !irq_enable_flag && (!irq_pending_flag || $past(qual_event)))
    else $error("accept did not clear flags");

  AST_VECTOR: assert property (@(posedge clk) disable iff (!arst_n)
    s_accept |=> push_stack && vector_load && vector_addr == 12'h003 && push_addr == $past(next_pc))
    else $error("vector or push wrong");

  AST_PEND_SET: assert property (@(posedge clk) disable iff (!arst_n)
    qual_event |=> irq_pending_flag)
    else $error("event did not set pending");

  AST_PEND_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    irq_pending_flag && !irq_enable_flag |=> irq_pending_flag)
    else $error("pending lost while disabled");

  AST_UNMASK: assert property (@(posedge clk) disable iff (!arst_n)
    unmask_irq_op && !mask_irq_op && !accept |=> irq_enable_flag)
    else $error("unmask did not enable");

  AST_MASK: assert property (@(posedge clk) disable iff (!arst_n)
    mask_irq_op |=> !irq_enable_flag)
    else $error("mask did not disable");

  AST_WRITE_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    write_flags_op |=> flags_r[1:0] == $past(acc_in[1:0]))
    else $error("flag write wrong");

  AST_QUAL_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
    qstate_r == QS_IDLE && sel_edge |=> !qual_event [*8])
    else $error("edge taken without delay");

  AST_RES_PIN: assert property (@(posedge clk) disable iff (!arst_n)
    read_interval_op && !read_flags_op |=> acc_out[2] == $past(pin_lvl) && acc_out[3] == 1'b0)
    else $error("interval read wrong");

  AST_CLS_ORDER: assert property (@(posedge clk) disable iff (!arst_n)
    cls_r[RES_WORD_END] |-> cls_r[RES_BIT_DATA])
    else $error("word end without bit data");
endmodule : ext_interrupt_pulse_decoder
`default_nettype wire

// file: design/ext_irq_pkg.sv
// Constants and types shared by the external interrupt unit
package ext_irq_pkg;
  // Clock and time base
  localparam int CLK_HZ           = 40_000_000;
  localparam int REF_FAST_NS      = 64_000;
  localparam int REF_FAST_CYC     = (REF_FAST_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int PRESCALE_W       = 13;

  // Flag register field positions
  localparam int FLG_EDGE_BIT     = 0;
  localparam int FLG_REFCLK_BIT   = 1;
  localparam int FLG_ENABLE_BIT   = 2;
  localparam int FLG_PENDING_BIT  = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Interval result field positions
  localparam int RES_BIT_DATA     = 0;
  localparam int RES_WORD_END     = 1;
  localparam int RES_PIN_LEVEL    = 2;
  localparam logic [2:0] RESULT_RESET = 3'h0;

  // Qualification delay in reference ticks (64..128 us at 64 us ticks)
  localparam logic [1:0] QUAL_TICKS = 2'h2;

  // Classification thresholds in reference ticks (same count for both rates)
  localparam int BIT_THRESH_NS    = 1_540_000;
  localparam int WORD_THRESH_NS   = 3_200_000;
  localparam int INTV_W           = 7;
  localparam logic [INTV_W-1:0] BIT_THRESH  = 7'(BIT_THRESH_NS / REF_FAST_NS);
  localparam logic [INTV_W-1:0] WORD_THRESH = 7'(WORD_THRESH_NS / REF_FAST_NS);

  // Interrupt vector
  localparam logic [11:0] IRQ_VECTOR = 12'h003;

  // Qualifier state
  typedef enum logic [1:0] {
    QS_IDLE = 2'b00,
    QS_WAIT = 2'b01,
    QS_FIRE = 2'b10
  } qual_state_type;
endpackage : ext_irq_pkg

// file: design/pin_sync.sv
// Three-stage synchroniser for the interrupt pin with agreement check
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb begin
    sh_nxt    = {sh_r[1:0], pin};
    level_nxt = level_r;
    // Change counts only when stages two and three agree
    if (sh_r[1] == sh_r[2]) begin
      level_nxt = sh_r[2];
    end
  end

  // Pin idles high through its pull-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r    <= 3'h7;
      level_r <= 1'b1;
    end else begin
      sh_r    <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule : pin_sync
`default_nettype wire

// file: design/ref_tick_gen.sv
// Reference tick divider: 64 us or 128 us enable pulse
`timescale 1ns/10ps
`default_nettype none
module ref_tick_gen
  import ext_irq_pkg::*;
#(
  parameter int FAST_CYC = REF_FAST_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic slow_sel,
  output logic      tick
);
  logic [PRESCALE_W-1:0] cnt_r;
  logic [PRESCALE_W-1:0] cnt_nxt;
  logic                  half_r;
  logic                  half_nxt;
  logic                  wrap;
  logic                  tick_nxt;
  logic                  tick_r;

  always_comb begin
    wrap     = (cnt_r == PRESCALE_W'(FAST_CYC - 1));
    cnt_nxt  = wrap ? '0 : cnt_r + 1'b1;
    half_nxt = wrap ? ~half_r : half_r;
    tick_nxt = wrap && (!slow_sel || half_r);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : ref_tick_gen
`default_nettype wire
